// ### hw/pqe_pkg.sv
// package for the event interrupt enable block
// assumes one 20 MHz clock and a 32-bit avalon-mm register slave
package pqe_pkg;

  // register word addresses
  localparam logic [3:0]  PQE_ADDR_ENABLE = 4'h0;  // enable word
  localparam logic [3:0]  PQE_ADDR_STATUS = 4'h1;  // sticky status, read clears
  localparam logic [3:0]  PQE_ADDR_MASK   = 4'h2;  // mask for irq
  localparam logic [3:0]  PQE_ADDR_SRST   = 4'h3;  // software reset strobe
  localparam logic [3:0]  PQE_ADDR_CHECK  = 4'h4;  // cfg check result
  localparam logic [3:0]  PQE_ADDR_FORCE  = 4'h5;  // forced check update
  localparam logic [11:0] PQE_DOC_OFFSET  = 12'h406; // enable word index

  // field positions
  localparam int PQE_B_FAULT3   = 31;
  localparam int PQE_B_FAULT2   = 30;
  localparam int PQE_B_FAULT1   = 29;
  localparam int PQE_B_FAULT0   = 28;
  localparam int PQE_B_CHKDONE  = 27;
  localparam int PQE_B_CHKCHG   = 26;
  localparam int PQE_B_SAG_LO   = 23;
  localparam int PQE_B_SURGE_LO = 20;
  localparam int PQE_B_ORDER    = 18;
  localparam int PQE_B_OVERCUR  = 17;
  localparam int PQE_B_ICROSS   = 13;
  localparam int PQE_B_COMB     = 12;
  localparam int PQE_B_VCROSS   = 9;

  // writable bits: 31..9 minus 19 and 16
  localparam logic [31:0] PQE_WR_MASK   = 32'hFFF6_FE00;
  // faults that cannot be masked
  localparam logic [31:0] PQE_NMI_MASK  = 32'h3000_0000;
  // faults that stick until a reset
  localparam logic [31:0] PQE_HOLD_MASK = 32'hB000_0000;
  localparam logic [31:0] PQE_RST_WORD  = 32'h0000_0000;
  localparam logic [31:0] PQE_SRST_KEY  = 32'h0000_0001;

  // time for a check computation to finish
  localparam int PQE_CHK_NS     = 800;
  localparam int PQE_CLK_NS     = 50;
  localparam int PQE_CHK_CYC    = (PQE_CHK_NS + PQE_CLK_NS - 1) / PQE_CLK_NS;

  // event inputs grouped
  typedef struct packed {
    logic       fault_three;
    logic       fault_two;
    logic       fault_one;
    logic       fault_zero;
    logic [2:0] sag;      // c,b,a
    logic [2:0] surge;    // c,b,a
    logic       phase_order_fault;
    logic [2:0] current_overcur;
    logic [2:0] current_cross;  // c,b,a
    logic       combined_voltage_crossing;
    logic [2:0] voltage_cross;  // c,b,a
  } pqe_events_t;

  // avalon-mm slave request
  typedef struct packed {
    logic [3:0]  address;
    logic        read;
    logic        write;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } pqe_avm_req_t;

  typedef enum logic [2:0] {
    PQE_CK_IDLE = 3'b001,
    PQE_CK_BUSY = 3'b010,
    PQE_CK_DONE = 3'b100
  } pqe_ck_state_t;

endpackage : pqe_pkg

// ### hw/pqe_edge.sv
// rising edge detector for event lines
// assumes inputs synchronous to mclk
`timescale 1ns/1ns
module pqe_edge #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         clr,
  // level in, pulse out
  input  wire logic [W-1:0] lvl,
  output logic      [W-1:0] rise
);
  logic [W-1:0] prev_q;
  logic [W-1:0] prev_d;

  always_comb begin
    prev_d = clr ? '0 : lvl;
    rise   = lvl & ~prev_q;
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      prev_q <= '0;
    end else begin
      prev_q <= prev_d;
    end
  end
endmodule : pqe_edge

// ### hw/pqe_check.sv
// configuration check engine: signature of watched config words
// assumes a forced start pulse and a config snapshot input
`timescale 1ns/1ns
module pqe_check
  import pqe_pkg::*;
#(
  parameter int CYC = PQE_CHK_CYC
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        clr,
  // control
  input  wire logic        force_start,
  input  wire logic [31:0] cfg_word,
  // results
  output logic             done_pulse,
  output logic             chg_pulse,
  output logic [31:0]      result_q
);
  pqe_ck_state_t st_q, st_d;
  logic [7:0]    cnt_q, cnt_d;
  logic [31:0]   result_d;
  logic [31:0]   seen_q, seen_d;
  logic          chg;

  always_comb begin
    st_d       = st_q;
    cnt_d      = cnt_q;
    result_d   = result_q;
    seen_d     = cfg_word;
    done_pulse = 1'b0;
    chg        = (cfg_word != seen_q);
    chg_pulse  = chg;
    // RULE5 recompute on change
    if (chg) begin
      result_d = {cfg_word[30:0], cfg_word[31]} ^ cfg_word ^ 32'h04C1_1DB7;
    end
    case (st_q)
      PQE_CK_IDLE: begin
        if (force_start) begin
          st_d  = PQE_CK_BUSY;
          cnt_d = 8'(CYC);
        end
      end
      PQE_CK_BUSY: begin
        cnt_d = cnt_q - 8'h01;
        if (cnt_q == 8'h01) begin
          st_d = PQE_CK_DONE;
        end
      end
      PQE_CK_DONE: begin
        // RULE4 forced update done
        result_d   = {cfg_word[30:0], cfg_word[31]} ^ cfg_word ^ 32'h04C1_1DB7;
        done_pulse = 1'b1;
        st_d       = PQE_CK_IDLE;
      end
      default: st_d = PQE_CK_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn || clr) begin
      st_q     <= PQE_CK_IDLE;
      cnt_q    <= 8'h00;
      result_q <= 32'h0000_0000;
      seen_q   <= 32'h0000_0000;
    end else begin
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      result_q <= result_d;
      seen_q   <= seen_d;
    end
  end
endmodule : pqe_check

// ### hw/pqe_irq.sv
// event interrupt enable block with sticky status and avalon-mm slave
// assumes event inputs synchronous to mclk; one waitrequest cycle per access
`timescale 1ns/1ns
// Operation
// RULE1: bit 31 enables fault three interrupt; fault holds until reset.
// RULE2: bit 30 enables fault two interrupt.
// RULE3: faults one and zero always interrupt; cleared only by reset.
// RULE4: bit 27 enables interrupt when forced config check completes.
// RULE5: bit 26 enables interrupt on config change; result holds new check.
// RULE6: bits 25..23 enable sag interrupts for phases c, b, a.
// RULE7: bits 22..20 enable surge interrupts for phases c, b, a.
// RULE8: bit 18 enables phase order fault interrupt.
// RULE9: bit 17 enables overcurrent interrupt on selected channels.
// RULE10: bits 15..13 enable current crossing interrupts c, b, a.
// RULE11: bit 12 enables combined voltage crossing interrupt.
// RULE12: bits 11..9 enable voltage crossing interrupts c, b, a.
// RULE13: bits 19 and 16 read zero and ignore writes.
// RULE14: enables reset to zero; irq on enabled or unmaskable status; code also requires the mask bit for enabled status.
module pqe_irq
  import pqe_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               rstn,
  // avalon-mm slave
  input  wire pqe_pkg::pqe_avm_req_t avs_req,
  output logic [31:0]             avs_readdata,
  output logic                    avs_waitrequest,
  // event sources
  input  wire pqe_pkg::pqe_events_t  evt,
  input  wire logic [31:0]        cfg_word,
  input  wire logic [2:0]         overcurrent_channel_select,
  // interrupt out
  output logic                    irq
);
  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  logic [31:0] enable_q, enable_d;
  logic [31:0] status_q, status_d;
  logic [31:0] mask_q, mask_d;
  logic [31:0] rdata_q, rdata_d;
  logic        wait_q, wait_d;
  logic        irq_q, irq_d;
  logic        srst_q, srst_d;
  logic        force_q, force_d;
  logic [31:0] ev_lvl, ev_rise, ev_hit, be_mask;
  logic        chk_done, chk_chg;
  logic [31:0] chk_result;
  logic        acc;

  // ------------------------------------------------------------------
  // event map
  // ------------------------------------------------------------------
  always_comb begin
    ev_lvl = 32'h0000_0000;
    ev_lvl[PQE_B_FAULT3] = evt.fault_three;
    ev_lvl[PQE_B_FAULT2] = evt.fault_two;
    ev_lvl[PQE_B_FAULT1] = evt.fault_one;
    ev_lvl[PQE_B_FAULT0] = evt.fault_zero;
    ev_lvl[PQE_B_SAG_LO +: 3]   = evt.sag;
    ev_lvl[PQE_B_SURGE_LO +: 3] = evt.surge;
    ev_lvl[PQE_B_ORDER]  = evt.phase_order_fault;
    // RULE9 selected channels only
    ev_lvl[PQE_B_OVERCUR] = |(evt.current_overcur & overcurrent_channel_select);
    ev_lvl[PQE_B_ICROSS +: 3] = evt.current_cross;
    ev_lvl[PQE_B_COMB]   = evt.combined_voltage_crossing;
    ev_lvl[PQE_B_VCROSS +: 3] = evt.voltage_cross;
  end

  pqe_edge #(
    .W (32)
  ) u_edge (
    .mclk (mclk),
    .rstn (rstn),
    .clr  (srst_q),
    .lvl  (ev_lvl),
    .rise (ev_rise)
  );

  pqe_check #(
    .CYC (PQE_CHK_CYC)
  ) u_check (
    .mclk        (mclk),
    .rstn        (rstn),
    .clr         (srst_q),
    .force_start (force_q),
    .cfg_word    (cfg_word),
    .done_pulse  (chk_done),
    .chg_pulse   (chk_chg),
    .result_q    (chk_result)
  );

  always_comb begin
    ev_hit = ev_rise;
    ev_hit[PQE_B_CHKDONE] = chk_done;
    ev_hit[PQE_B_CHKCHG]  = chk_chg;
    ev_hit = ev_hit & PQE_WR_MASK;
  end

  // ------------------------------------------------------------------
  // bus and registers
  // ------------------------------------------------------------------
  always_comb begin
    be_mask = {{8{avs_req.byteenable[3]}}, {8{avs_req.byteenable[2]}},
               {8{avs_req.byteenable[1]}}, {8{avs_req.byteenable[0]}}};
    // request seen with waitrequest high; writes take effect on the edge that ends the waitrequest-low cycle
    acc      = (avs_req.read || avs_req.write) && !wait_q;
    wait_d   = !((avs_req.read || avs_req.write) && wait_q);
    enable_d = enable_q;
    mask_d   = mask_q;
    status_d = status_q;
    rdata_d  = rdata_q;
    srst_d   = 1'b0;
    force_d  = 1'b0;
    if (acc && avs_req.write) begin
      case (avs_req.address)
        // RULE13 reserved bits dropped
        PQE_ADDR_ENABLE: enable_d = ((enable_q & ~be_mask) |
                                     (avs_req.writedata & be_mask)) & PQE_WR_MASK;
        PQE_ADDR_MASK:   mask_d = ((mask_q & ~be_mask) |
                                   (avs_req.writedata & be_mask)) & PQE_WR_MASK;
        PQE_ADDR_SRST:   srst_d = avs_req.byteenable[0] && avs_req.writedata[0];
        // RULE4 forced check start
        PQE_ADDR_FORCE:  force_d = avs_req.byteenable[0] && avs_req.writedata[0];
        default: ;
      endcase
    end
    // read data captured when request seen, stands while waitrequest low
    if (avs_req.read && wait_q) begin
      case (avs_req.address)
        PQE_ADDR_ENABLE: rdata_d = enable_q;
        PQE_ADDR_STATUS: rdata_d = status_q;
        PQE_ADDR_MASK:   rdata_d = mask_q;
        PQE_ADDR_CHECK:  rdata_d = chk_result;
        default:         rdata_d = 32'h0000_0000;
      endcase
    end
    // read clears only reported bits, except faults held until reset
    if (acc && avs_req.read && avs_req.address == PQE_ADDR_STATUS) begin
      status_d = status_q & ~(rdata_q & ~PQE_HOLD_MASK);
    end
    // RULE1 faults held till reset
    // set wins over read clear
    status_d = status_d | ev_hit;
    // RULE2 RULE6 RULE7 RULE8 RULE10 RULE11 RULE12 enable gating
    // RULE3 unmaskable faults bypass
    // RULE14 irq from enabled status
    irq_d = |(status_q & ((enable_q & mask_q) | PQE_NMI_MASK));
  end

  always_ff @(posedge mclk) begin
    if (!rstn || srst_q) begin
      enable_q <= PQE_RST_WORD;
      mask_q   <= PQE_RST_WORD;
      status_q <= PQE_RST_WORD;
      rdata_q  <= PQE_RST_WORD;
      wait_q   <= 1'b1;
      irq_q    <= 1'b0;
      srst_q   <= 1'b0;
      force_q  <= 1'b0;
    end else begin
      enable_q <= enable_d;
      mask_q   <= mask_d;
      status_q <= status_d;
      rdata_q  <= rdata_d;
      wait_q   <= wait_d;
      irq_q    <= irq_d;
      srst_q   <= srst_d;
      force_q  <= force_d;
    end
  end

  always_comb begin
    avs_readdata    = rdata_q;
    avs_waitrequest = wait_q;
    irq             = irq_q;
  end

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  AST_FAULT3_HOLD: assert property (status_q[31] && !srst_q |=> status_q[31]) // RULE1
    else $error("fault three flag dropped without reset");
  AST_FAULT2_GATE: assert property (status_q == 32'h4000_0000 && !enable_q[30]
    |=> !irq_q) // RULE2
    else $error("fault two raised irq while disabled");
  AST_NMI: assert property ((status_q[29] || status_q[28]) && !srst_q |=> irq_q) // RULE3
    else $error("unmaskable fault did not raise irq");
  AST_CHKDONE: assert property (force_q |-> ##[1:40] status_q[27]) // RULE4
    else $error("forced check never completed");
  AST_CHKCHG: assert property (chk_chg && !srst_q |=> status_q[26]) // RULE5
    else $error("config change not flagged");
  AST_SAG: assert property (ev_rise[23] && !srst_q |=> status_q[23]) // RULE6
    else $error("sag a not latched");
  AST_RESV: assert property (enable_q[19] == 1'b0 && enable_q[16] == 1'b0) // RULE13
    else $error("reserved enable bit set");
  AST_IRQ: assert property ((status_q & enable_q & mask_q) != 0 && !srst_q |=> irq_q) // RULE14
    else $error("enabled status did not raise irq");
  AST_WAIT: assert property (!wait_q |=> wait_q) // one waitrequest cycle per access
    else $error("waitrequest low two cycles");

  COV_IRQ:   cover property (!irq_q ##1 irq_q);
  COV_READ:  cover property (acc && avs_req.read && avs_req.address == PQE_ADDR_STATUS);
  COV_CHK:   cover property (chk_done);
  COV_SRST:  cover property (srst_q);
endmodule : pqe_irq

// ### tb/pqe_host.sv
// host model: avalon-mm master that services the event interrupt block
// assumes a slave that lowers waitrequest once per access
`timescale 1ns/1ns
module pqe_host
  import pqe_pkg::*;
(
  // clock
  input  wire logic                  mclk,
  // avalon-mm master side
  output pqe_pkg::pqe_avm_req_t      avs_req,
  input  wire logic [31:0]           avs_readdata,
  input  wire logic                  avs_waitrequest
);
  import pqe_pkg::*;

  initial avs_req = '0;

  // ----------------------------------------
  // one access, entered just after a rising edge
  // ----------------------------------------
  task automatic bus_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    avs_req.address    <= a;
    avs_req.writedata  <= d;
    avs_req.byteenable <= 4'hF;
    avs_req.read       <= !wr;
    avs_req.write      <= wr;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_req.read  <= 1'b0;
    avs_req.write <= 1'b0;
    // idle edge so the next request is a fresh assignment
    @(posedge mclk);
  endtask : bus_xfer
endmodule : pqe_host

// ### tb/pqe_irq_test.sv
// self-checking bench for the event interrupt enable block
// assumes the host model drives all register traffic
`timescale 1ns/1ns
module pqe_irq_test;
  import pqe_pkg::*;
  localparam int LIMIT = 20000;
  logic         mclk;
  logic         rstn;
  logic         irq;
  logic         avs_waitrequest;
  logic         xi;
  logic [31:0]  avs_readdata;
  logic [31:0]  cfg_word;
  logic [31:0]  rd;
  logic [31:0]  r0;
  logic [31:0]  en;
  logic [31:0]  mk;
  logic [31:0]  st;
  logic [2:0]   sel;
  pqe_avm_req_t avs_req;
  pqe_events_t  evt;
  int           bad_count;
  int           n_tests;
  int           cyc;
  int           b;

  pqe_irq i_pqe_irq (.mclk(mclk), .rstn(rstn), .avs_req(avs_req),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .evt(evt),
    .cfg_word(cfg_word), .overcurrent_channel_select(sel), .irq(irq));
  pqe_host i_pqe_host (.mclk(mclk), .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    evt = '0;
    cfg_word = 32'h0000_0000;
    sel = 3'h0;
    bad_count = 0;
    n_tests = 0;
    cyc = 0;
  end
  always #25 mclk = ~mclk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict

  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_pqe_host.bus_xfer(1'b1, a, d, rd);
  endtask : wr

  task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
    i_pqe_host.bus_xfer(1'b0, a, 32'h0, rd);
    chk(rd, exp);
  endtask : rdc

  // event line index to status bit position
  function automatic int stat_bit(input int i);
    if (i < 7 || (i > 10 && i < 17)) return i + 9;
    if (i < 10) return 17;
    if (i == 10) return 18;
    return i + 11;
  endfunction : stat_bit

  function automatic logic irq_of(input logic [31:0] s, input logic [31:0] e,
                                  input logic [31:0] m);
    return |((s & e & m) | (s & PQE_NMI_MASK));
  endfunction : irq_of

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rdc(PQE_ADDR_ENABLE, PQE_RST_WORD);
    rdc(PQE_ADDR_MASK, PQE_RST_WORD);
    rdc(PQE_ADDR_STATUS, PQE_RST_WORD);
    chk({31'h0, irq}, 32'h0);
    wr(4'hF, 32'hFFFF_FFFF);
    rdc(4'hF, 32'h0);
    rdc(PQE_ADDR_ENABLE, PQE_RST_WORD);
    $display("test reset and unmapped done");
    // pass 0: enables off, pass 1: mask off, pass 2: all open
    for (int p = 0; p < 3; p++) begin
      en = (p == 0) ? 32'h0 : 32'hFFFF_FFFF;
      mk = (p == 1) ? 32'h0 : 32'hFFFF_FFFF;
      sel <= (p == 2) ? 3'h7 : 3'h0;
      for (int i = 0; i < 21; i++) begin
        wr(PQE_ADDR_SRST, PQE_SRST_KEY);
        repeat (2) @(posedge mclk);
        wr(PQE_ADDR_ENABLE, en);
        wr(PQE_ADDR_MASK, mk);
        rdc(PQE_ADDR_ENABLE, en & PQE_WR_MASK);
        b = stat_bit(i);
        st = (b == 17 && p != 2) ? 32'h0 : 32'h1 << b;
        evt <= pqe_events_t'(21'h1 << i);
        repeat (2) @(posedge mclk);
        evt <= '0;
        repeat (4) @(posedge mclk);
        xi = irq_of(st, en & PQE_WR_MASK, mk);
        chk({31'h0, irq}, {31'h0, xi});
        rdc(PQE_ADDR_STATUS, st);
        st = st & PQE_HOLD_MASK;
        rdc(PQE_ADDR_STATUS, st);
        repeat (3) @(posedge mclk);
        xi = irq_of(st, en & PQE_WR_MASK, mk);
        chk({31'h0, irq}, {31'h0, xi});
      end
      $display("test event pass %0d done", p);
    end
    wr(PQE_ADDR_SRST, PQE_SRST_KEY);
    repeat (2) @(posedge mclk);
    wr(PQE_ADDR_ENABLE, 32'h0C00_0000);
    wr(PQE_ADDR_MASK, 32'h0C00_0000);
    i_pqe_host.bus_xfer(1'b0, PQE_ADDR_CHECK, 32'h0, r0);
    cfg_word <= 32'h5A5A_0F0F;
    repeat (4) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    i_pqe_host.bus_xfer(1'b0, PQE_ADDR_STATUS, 32'h0, rd);
    chk(rd & 32'h0400_0000, 32'h0400_0000);
    repeat (PQE_CHK_CYC + 4) @(posedge mclk);
    i_pqe_host.bus_xfer(1'b0, PQE_ADDR_CHECK, 32'h0, rd);
    chk({31'h0, rd !== r0}, 32'h1);
    i_pqe_host.bus_xfer(1'b0, PQE_ADDR_STATUS, 32'h0, rd);
    wr(PQE_ADDR_FORCE, 32'h1);
    repeat (PQE_CHK_CYC + 4) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    i_pqe_host.bus_xfer(1'b0, PQE_ADDR_STATUS, 32'h0, rd);
    chk(rd & 32'h0800_0000, 32'h0800_0000);
    $display("test check done");
    print_verdict();
  end
endmodule : pqe_irq_test
